// ### rtl/bth_regs.vh
// Register offsets, field positions and fixed values of the bridge header.
`ifndef BTH_REGS_VH
`define BTH_REGS_VH
`define BTH_OFS_CMD_STS     12'h004
`define BTH_OFS_REV_CLASS   12'h008
`define BTH_OFS_CLS_HDR     12'h00C
`define BTH_OFS_BUS_NUM     12'h018
`define BTH_OFS_IO_WIN      12'h01C
`define BTH_OFS_IO_UPPER    12'h030
`define BTH_CMD_IO_EN       0
`define BTH_CMD_MEM_EN      1
`define BTH_CMD_MASTER_EN   2
`define BTH_CMD_PARITY_EN   6
`define BTH_CMD_SYSTEM_ERROR_REPORT_ENABLE_EN     8
`define BTH_CMD_INTX_DIS    10
`define BTH_STS_INT         19
`define BTH_STS_CAP_LIST    20
`define BTH_STS_MDPE        24
`define BTH_STS_STA         27
`define BTH_STS_RTA         28
`define BTH_STS_RMA         29
`define BTH_STS_SSE         30
`define BTH_STS_DPE         31
`define BTH_CLASS_CODE      24'h060400
`define BTH_HDR_TYPE        8'h01
`define BTH_IO_32BIT        4'h1
`endif

// ### rtl/bth_config_header.v
// Type-1 bridge configuration header, lower part, with an APB slave.
`timescale 1ns/100ps
// Functional notes
// - I/O accepted only while I/O enable set
// - Memory accepted only while memory enable set
// - Bus master enable gates upstream, else UR
// - Legacy controls read zero, ignore writes
// - Parity response enable gates parity handling
// - Error reports only while error enable set
// - Interrupt disable blocks own INTx only
// - Interrupt status always reads zero
// - Capabilities list bit reads one
// - Parity status set only with response enable
// - Completer abort sent sets status bit
// - Completer abort received sets status bit
// - Unsupported request received sets status bit
// - Error message sent sets status bit
// - Poisoned TLP received sets status bit
// - Revision is a fixed hardwired value
// - Class code reads bridge, PCI-to-PCI
// - Cache line size writable, no effect
// - Header type reads one
// - Three writable bus numbers, reset zero
// - I/O limit low nibble reads one
`include "bth_regs.vh"
module bth_config_header #(
    parameter [7:0] REVISION = 8'hA5  // Arbitrary value.
) (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // Error and completion events from the forwarding logic
    input  wire        ev_parity_err,
    input  wire        ev_cpl_abort_sent,
    input  wire        ev_cpl_abort_rcvd,
    input  wire        ev_cpl_ur_rcvd,
    input  wire        ev_err_msg_req,
    input  wire        ev_poisoned_rx,
    input  wire        ev_own_intx_req,
    // Request classification
    input  wire        pri_io_req,
    input  wire        pri_mem_req,
    input  wire        dn_up_req,
    input  wire [31:0] io_addr,
    // Enables to the forwarding logic
    output wire        io_accept,
    output wire        mem_accept,
    output wire        up_forward,
    output wire        up_unsupported,
    output wire        parity_action,
    output wire        err_msg_send,
    output wire        own_intx_send,
    output wire        io_in_window,
    output wire [7:0]  upstream_bus_number,
    output wire [7:0]  downstream_bus_number,
    output wire [7:0]  highest_bus_number
);

    //--------------------------------------------------------------
    // Storage
    //--------------------------------------------------------------
    reg  [15:0] cmd_q;
    reg  [31:16] sts_q;
    reg  [7:0]  cache_line_q;
    reg  [7:0]  pri_bus_q;
    reg  [7:0]  sec_bus_q;
    reg  [7:0]  sub_bus_q;
    reg  [3:0]  io_base_q;
    reg  [3:0]  io_limit_q;
    reg  [15:0] io_base_up_q;
    reg  [15:0] io_limit_up_q;
    reg  [15:0] cmd_d;
    reg  [31:16] sts_d;

    wire        wr_en = psel & penable & pwrite;
    wire        acc   = psel & penable;
    wire        mapped;

    function byte_hit;
        input [11:0] ofs;
        input [1:0]  lane;
        begin
            byte_hit = wr_en & (paddr == ofs) & pstrb[lane];
        end
    endfunction

    assign mapped = (paddr == `BTH_OFS_CMD_STS) |
                    (paddr == `BTH_OFS_REV_CLASS) |
                    (paddr == `BTH_OFS_CLS_HDR) |
                    (paddr == `BTH_OFS_BUS_NUM) |
                    (paddr == `BTH_OFS_IO_WIN) |
                    (paddr == `BTH_OFS_IO_UPPER);
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    //--------------------------------------------------------------
    // Command and status next values
    //--------------------------------------------------------------
    wire err_msg = ev_err_msg_req & cmd_q[`BTH_CMD_SYSTEM_ERROR_REPORT_ENABLE_EN];
    always @* begin
        cmd_d = cmd_q;
        if (byte_hit(`BTH_OFS_CMD_STS, 2'd0)) begin
            cmd_d[2:0] = pwdata[2:0];
            cmd_d[`BTH_CMD_PARITY_EN] = pwdata[6];
        end
        if (byte_hit(`BTH_OFS_CMD_STS, 2'd1)) begin
            cmd_d[`BTH_CMD_SYSTEM_ERROR_REPORT_ENABLE_EN]  = pwdata[8];
            cmd_d[`BTH_CMD_INTX_DIS] = pwdata[10];
        end
        cmd_d[5:3]   = 3'h0;
        cmd_d[7]     = 1'b0;
        cmd_d[9]     = 1'b0;
        cmd_d[15:11] = 5'h00;
        sts_d = sts_q;
        if (byte_hit(`BTH_OFS_CMD_STS, 2'd3)) begin
            if (pwdata[24])
                sts_d[`BTH_STS_MDPE] = 1'b0;
            if (pwdata[30])
                sts_d[`BTH_STS_SSE] = 1'b0;
            if (pwdata[31])
                sts_d[`BTH_STS_DPE] = 1'b0;
        end
        if (ev_parity_err & cmd_q[`BTH_CMD_PARITY_EN])
            sts_d[`BTH_STS_MDPE] = 1'b1;
        if (ev_cpl_abort_sent)
            sts_d[`BTH_STS_STA] = 1'b1;
        if (ev_cpl_abort_rcvd)
            sts_d[`BTH_STS_RTA] = 1'b1;
        if (ev_cpl_ur_rcvd)
            sts_d[`BTH_STS_RMA] = 1'b1;
        if (err_msg)
            sts_d[`BTH_STS_SSE] = 1'b1;
        if (ev_poisoned_rx)
            sts_d[`BTH_STS_DPE] = 1'b1;
        sts_d[18:16] = 3'h0;
        sts_d[21]    = 1'b0;
        sts_d[22]    = 1'b0;
        sts_d[23]    = 1'b0;
        sts_d[26:25] = 2'h0;
        sts_d[`BTH_STS_INT] = 1'b0;
        sts_d[`BTH_STS_CAP_LIST] = 1'b1;
    end

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q         <= 16'h0000;
            sts_q         <= 16'h0010;
            cache_line_q  <= 8'h00;
            pri_bus_q     <= 8'h00;
            sec_bus_q     <= 8'h00;
            sub_bus_q     <= 8'h00;
            io_base_q     <= 4'h0;
            io_limit_q    <= 4'h0;
            io_base_up_q  <= 16'h0000;
            io_limit_up_q <= 16'h0000;
        end else begin
            cmd_q <= cmd_d;
            sts_q <= sts_d;
            if (byte_hit(`BTH_OFS_CLS_HDR, 2'd0))
                cache_line_q <= pwdata[7:0];
            if (byte_hit(`BTH_OFS_BUS_NUM, 2'd0))
                pri_bus_q <= pwdata[7:0];
            if (byte_hit(`BTH_OFS_BUS_NUM, 2'd1))
                sec_bus_q <= pwdata[15:8];
            if (byte_hit(`BTH_OFS_BUS_NUM, 2'd2))
                sub_bus_q <= pwdata[23:16];
            if (byte_hit(`BTH_OFS_IO_WIN, 2'd0))
                io_base_q <= pwdata[7:4];
            if (byte_hit(`BTH_OFS_IO_WIN, 2'd1))
                io_limit_q <= pwdata[15:12];
            if (byte_hit(`BTH_OFS_IO_UPPER, 2'd0))
                io_base_up_q[7:0] <= pwdata[7:0];
            if (byte_hit(`BTH_OFS_IO_UPPER, 2'd1))
                io_base_up_q[15:8] <= pwdata[15:8];
            if (byte_hit(`BTH_OFS_IO_UPPER, 2'd2))
                io_limit_up_q[7:0] <= pwdata[23:16];
            if (byte_hit(`BTH_OFS_IO_UPPER, 2'd3))
                io_limit_up_q[15:8] <= pwdata[31:24];
        end
    end

    //--------------------------------------------------------------
    // Read data
    //--------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `BTH_OFS_CMD_STS:
                    prdata <= {sts_q, cmd_q};
                `BTH_OFS_REV_CLASS:
                    prdata <= {`BTH_CLASS_CODE, REVISION};
                `BTH_OFS_CLS_HDR:
                    prdata <= {8'h00, `BTH_HDR_TYPE, 8'h00, cache_line_q};
                `BTH_OFS_BUS_NUM:
                    prdata <= {8'h00, sub_bus_q, sec_bus_q, pri_bus_q};
                `BTH_OFS_IO_WIN:
                    prdata <= {16'h0000, io_limit_q, `BTH_IO_32BIT,
                               io_base_q, `BTH_IO_32BIT};
                `BTH_OFS_IO_UPPER:
                    prdata <= {io_limit_up_q, io_base_up_q};
                default:
                    prdata <= 32'h00000000;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Forwarding controls
    //--------------------------------------------------------------
    wire [31:0] io_base_addr  = {io_base_up_q, io_base_q, 12'h000};
    wire [31:0] io_limit_addr = {io_limit_up_q, io_limit_q, 12'hFFF};

    assign io_accept      = pri_io_req & cmd_q[`BTH_CMD_IO_EN];
    assign mem_accept     = pri_mem_req & cmd_q[`BTH_CMD_MEM_EN];
    assign up_forward     = dn_up_req & cmd_q[`BTH_CMD_MASTER_EN];
    assign up_unsupported = dn_up_req & ~cmd_q[`BTH_CMD_MASTER_EN];
    assign parity_action  = ev_parity_err & cmd_q[`BTH_CMD_PARITY_EN];
    assign err_msg_send   = err_msg;
    assign own_intx_send  = ev_own_intx_req & ~cmd_q[`BTH_CMD_INTX_DIS];
    assign io_in_window   = (io_addr >= io_base_addr) &
                            (io_addr <= io_limit_addr);
    assign upstream_bus_number   = pri_bus_q;
    assign downstream_bus_number = sec_bus_q;
    assign highest_bus_number    = sub_bus_q;

endmodule // bth_config_header

// ### sim/bth_chk.sv
// Concurrent checks on the bridge header ports.
`timescale 1ns/100ps
module bth_chk (
    // APB side
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata,
    input wire        pslverr,
    // Forwarding side
    input wire        pri_io_req,
    input wire        pri_mem_req,
    input wire        dn_up_req,
    input wire        ev_err_msg_req,
    input wire        io_accept,
    input wire        mem_accept,
    input wire        up_forward,
    input wire        up_unsupported,
    input wire        err_msg_send,
    input wire [7:0]  upstream_bus_number
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence s_wr;
        psel && penable && pwrite;
    endsequence
    property p_io; io_accept |-> pri_io_req; endproperty
    a_io: assert property (p_io)
        else $error("io accept without request");
    property p_mem; mem_accept |-> pri_mem_req; endproperty
    a_mem: assert property (p_mem)
        else $error("mem accept without request");
    property p_up; dn_up_req |-> up_forward != up_unsupported; endproperty
    a_up: assert property (p_up)
        else $error("upstream request not forwarded or refused");
    property p_err; err_msg_send |-> ev_err_msg_req; endproperty
    a_err: assert property (p_err)
        else $error("error message without cause");
    property p_bus;
        s_wr ##0 (paddr == 12'h018 && pstrb[0])
            |=> upstream_bus_number == $past(pwdata[7:0]);
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus number not written");
    property p_hold; !(psel && penable && pwrite)
        |=> $stable(upstream_bus_number); endproperty
    a_hold: assert property (p_hold)
        else $error("bus number changed without write");
    property p_cls; s_rd(12'h008) |=> prdata[31:8] == 24'h060400; endproperty
    a_cls: assert property (p_cls)
        else $error("class code wrong");
    property p_sts; s_rd(12'h004) |=> prdata[21:19] == 3'b010
        && prdata[26:25] == 2'h0 && !prdata[23] && prdata[5:3] == 3'h0
        && !prdata[7] && !prdata[9]; endproperty
    a_sts: assert property (p_sts)
        else $error("fixed status or command bits wrong");
    property p_hdr; s_rd(12'h00C) |=> prdata[23:8] == 16'h0100; endproperty
    a_hdr: assert property (p_hdr)
        else $error("header type or latency wrong");
endmodule // bth_chk
bind bth_config_header bth_chk u_chk (.*);

// ### sim/bth_fwd_model.sv
// Behavioural model of the port's forwarding logic.
`timescale 1ns/100ps
module bth_fwd_model (
    // Clock
    input wire        pclk,
    // Events and requests towards the header
    output reg        ev_parity_err,
    output reg        ev_cpl_abort_sent,
    output reg        ev_cpl_abort_rcvd,
    output reg        ev_cpl_ur_rcvd,
    output reg        ev_err_msg_req,
    output reg        ev_poisoned_rx,
    output reg        ev_own_intx_req,
    output reg        pri_io_req,
    output reg        pri_mem_req,
    output reg        dn_up_req,
    output reg [31:0] io_addr
);
    // Levels are held until the next call, which comes just after an edge.
    task drive(input [6:0] ev, input [2:0] rq, input [31:0] a);
        {ev_parity_err, ev_cpl_abort_sent, ev_cpl_abort_rcvd,
         ev_cpl_ur_rcvd, ev_err_msg_req, ev_poisoned_rx,
         ev_own_intx_req} <= ev;
        {pri_io_req, pri_mem_req, dn_up_req} <= rq;
        io_addr <= a;
    endtask
    initial drive(7'h00, 3'h0, 32'h0);
endmodule // bth_fwd_model

// ### sim/bth_config_header_tb.sv
// Self-checking bench for the bridge header block.
`timescale 1ns/100ps
module bth_config_header_tb;
    localparam [7:0] REV = 8'h3C;  // Arbitrary value.
    reg         pclk, presetn, psel, penable, pwrite, err;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    reg  [3:0]  pstrb;
    wire        pready, pslverr, ev_parity_err, ev_cpl_abort_sent;
    wire        ev_cpl_abort_rcvd, ev_cpl_ur_rcvd, ev_err_msg_req;
    wire        ev_poisoned_rx, ev_own_intx_req, pri_io_req, pri_mem_req;
    wire        dn_up_req, io_accept, mem_accept, up_forward;
    wire        up_unsupported, parity_action, err_msg_send;
    wire        own_intx_send, io_in_window;
    wire [31:0] prdata, io_addr;
    wire [7:0]  upstream_bus_number, downstream_bus_number;
    wire [7:0]  highest_bus_number;
    integer     n_errors = 0, num_checks = 0, i;
    bth_config_header #(.REVISION(REV)) uut (.*);
    bth_fwd_model fwd (.*);
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0s exp %h got %h", nm, exp, got);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rdc(input [11:0] a, input [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk("rdata", exp, rd);
    endtask
    task wrd(input [11:0] a, input [31:0] d, input [3:0] s, input [31:0] e);
        apb(1'b1, a, d, s);
        rdc(a, e);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        n_errors = n_errors + 1;
        end_sim;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(12'h004, 32'h0010_0000);
        chk("pslverr_mapped", 32'h0, err);
        rdc(12'h01C, 32'h0000_0101);
        wrd(12'h008, 32'hFFFF_FFFF, 4'hF, {24'h060400, REV});
        wrd(12'h00C, 32'hFFFF_FF77, 4'hF, 32'h0001_0077);
        wrd(12'h018, 32'hFFA5_5A3C, 4'hF, 32'h00A5_5A3C);
        chk("bus_numbers", 32'h00A5_5A3C, {8'h00, highest_bus_number,
            downstream_bus_number, upstream_bus_number});
        wrd(12'h01C, 32'hFFFF_5030, 4'hF, 32'h0000_5131);
        wrd(12'h030, 32'h0002_0001, 4'hF, 32'h0002_0001);
        wrd(12'h010, 32'hFFFF_FFFF, 4'hF, 32'h0);
        chk("pslverr", 32'h1, err);
        for (i = 0; i < 2; i = i + 1) begin
            apb(1'b1, 12'h004, i ? 32'h0000_FFFF : 32'h0, 4'h3);
            fwd.drive(7'h7F, 3'h7, 32'h0);
            @(posedge pclk);
            chk("io_accept", i, io_accept);
            chk("mem_accept", i, mem_accept);
            chk("up_forward", i, up_forward);
            chk("up_unsupported", !i, up_unsupported);
            chk("parity_action", i, parity_action);
            chk("err_msg_send", i, err_msg_send);
            chk("own_intx_send", !i, own_intx_send);
            fwd.drive(7'h00, 3'h0, 32'h0);
            rdc(12'h004, i ? 32'hF910_0547 : 32'hB810_0000);
            wrd(12'h004, 32'hFF00_0000, 4'h8,
                i ? 32'h3810_0547 : 32'h3810_0000);
        end
        // Parity event lands on the same edge as its clearing write.
        fork
            apb(1'b1, 12'h004, 32'h0100_0547, 4'hF);
            begin
                @(posedge pclk);
                fwd.drive(7'h40, 3'h0, 32'h0);
                @(posedge pclk);
                fwd.drive(7'h00, 3'h0, 32'h0);
            end
        join
        rdc(12'h004, 32'h3910_0547);
        wrd(12'h004, 32'h0000_0547, 4'hF, 32'h3910_0547);
        for (i = 0; i < 4; i = i + 1) begin
            fwd.drive(7'h00, 3'h4, (i[1] ? 32'h0002_5FFF : 32'h0001_2FFF)
                + i[0]);
            @(posedge pclk);
            @(posedge pclk);
            chk("io_in_window", i[0] ^ i[1], io_in_window);
        end
        end_sim;
    end
endmodule // bth_config_header_tb
